// >>> rtl/ube_control.sv
// break, edge, polarity, ninth bit and error control slice of a serial port
`timescale 1ns/1ps
module ube_control
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// apb slave
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [7:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]     prdata,
	output logic            pready,
	output logic            pslverr,
	// configuration from the rest of the port
	input  wire logic       nine_bit_mode,
	input  wire logic       receiver_standby,
	input  wire logic       loop_select,
	input  wire logic       receive_source_select,
	input  wire logic       bit_tick,
	// receiver events from the shifter
	input  wire logic       rx_char_done,
	input  wire logic       rx_ninth_in,
	input  wire logic       rx_framing_bad,
	input  wire logic       rx_noise_seen,
	input  wire logic       rx_parity_bad,
	// flag clearing strobes
	input  wire logic       status_one_read,
	input  wire logic       data_reg_read,
	// transmit side
	input  wire logic       tx_data_write,
	input  wire logic [7:0] tx_data_byte,
	input  wire logic       send_break_req,
	input  wire logic       tx_shift_bit,
	output logic [8:0]      tx_frame,
	output logic            tx_frame_load,
	output logic            tx_break_busy,
	// receive line as seen by the receiver
	output logic            rx_line,
	output logic            idle_flag_set,
	// status to the rest of the port
	output logic            rx_buffer_full_flag,
	output logic            overrun_flag,
	output logic            noise_flag,
	output logic            framing_error_flag,
	output logic            parity_error_flag,
	output logic            error_irq,
	// pins
	input  wire logic       rxd_i,
	input  wire logic       txd_i,
	output logic            txd_o,
	output logic            txd_oe
);

	// ==========================================================
	// state
	typedef struct packed
	{
		logic        lin_break_flag;
		logic        rx_edge_flag;
		logic        rx_invert;
		logic        wake_idle_report;
		logic        long_break_tx;
		logic        lin_break_detect_enable;
		logic        receiver_active_flag;
		logic        rx_ninth_bit;
		logic        tx_ninth_bit;
		logic        single_wire_tx_direction;
		logic        tx_invert;
		logic        overrun_irq_enable;
		logic        noise_irq_enable;
		logic        framing_irq_enable;
		logic        parity_irq_enable;
		logic        overrun_flag;
		logic        noise_flag;
		logic        framing_error_flag;
		logic        parity_error_flag;
		logic        rx_buffer_full_flag;
		logic [4:0]  clear_armed;
		logic        line_prev;
		logic        break_active;
		logic [31:0] prdata;
		logic        pslverr;
		logic [8:0]  tx_frame;
		logic        tx_load;
		logic        idle_set;
		logic        txd_o;
	} ube_state_type;

	ube_state_type state_reg;
	ube_state_type state_next;

	// ==========================================================
	// address decode
	function automatic logic [1:0] decode(input logic [7:0] addr);
		logic [1:0] sel;
		sel = 2'b00;
		if (addr == ube_pkg::STATUS_TWO_OFFSET)
		begin
			sel = 2'b01;
		end
		else if (addr == ube_pkg::CONTROL_THREE_OFFSET)
		begin
			sel = 2'b10;
		end
		return sel;
	endfunction

	logic [1:0] addr_sel;
	logic       setup_phase;
	logic       write_access;
	logic [7:0] status_two_value;
	logic [7:0] control_three_value;

	assign addr_sel = decode(paddr);
	assign setup_phase = psel && !penable;
	assign write_access = psel && penable && pwrite;

	// ==========================================================
	// read views
	always_comb
	begin
		status_two_value = 8'h00;
		status_two_value[ube_pkg::S2_LIN_BREAK_FLAG]   = state_reg.lin_break_flag;
		status_two_value[ube_pkg::S2_RX_EDGE_FLAG]     = state_reg.rx_edge_flag;
		status_two_value[ube_pkg::S2_RX_INVERT]        = state_reg.rx_invert;
		status_two_value[ube_pkg::S2_WAKE_IDLE_REPORT] = state_reg.wake_idle_report;
		status_two_value[ube_pkg::S2_LONG_BREAK_TX]    = state_reg.long_break_tx;
		status_two_value[ube_pkg::S2_LIN_BREAK_DETECT] = state_reg.lin_break_detect_enable;
		status_two_value[ube_pkg::S2_RECEIVER_ACTIVE]  = state_reg.receiver_active_flag;
		control_three_value = 8'h00;
		control_three_value[ube_pkg::C3_RX_NINTH_BIT]   = state_reg.rx_ninth_bit;
		control_three_value[ube_pkg::C3_TX_NINTH_BIT]   = state_reg.tx_ninth_bit;
		control_three_value[ube_pkg::C3_TX_DIRECTION]   = state_reg.single_wire_tx_direction;
		control_three_value[ube_pkg::C3_TX_INVERT]      = state_reg.tx_invert;
		control_three_value[ube_pkg::C3_OVERRUN_IRQ_EN] = state_reg.overrun_irq_enable;
		control_three_value[ube_pkg::C3_NOISE_IRQ_EN]   = state_reg.noise_irq_enable;
		control_three_value[ube_pkg::C3_FRAMING_IRQ_EN] = state_reg.framing_irq_enable;
		control_three_value[ube_pkg::C3_PARITY_IRQ_EN]  = state_reg.parity_irq_enable;
	end

	// ==========================================================
	// receive line selection and polarity
	logic single_wire;
	logic line_raw;
	logic line_now;
	logic edge_seen;

	assign single_wire = loop_select && receive_source_select;

	always_comb
	begin
		if (single_wire)
		begin
			line_raw = txd_i;
		end
		else if (loop_select)
		begin
			line_raw = state_reg.txd_o;
		end
		else
		begin
			line_raw = rxd_i;
		end
	end

	// inverted line feeds data, start, stop, break and idle sampling alike
	assign line_now = line_raw ^ state_reg.rx_invert;
	// falling edge of the corrected line is the active edge in both polarities
	assign edge_seen = state_reg.line_prev && !line_now;

	// ==========================================================
	// bit time counters
	logic [3:0] char_times;
	logic [3:0] break_threshold;
	logic [3:0] break_length;
	logic       break_hit;
	logic       idle_hit;
	logic       tx_break_hit;

	assign char_times = ube_pkg::CHAR_BIT_TIMES + {3'h0, nine_bit_mode};
	assign break_threshold = char_times + (state_reg.lin_break_detect_enable ?
		ube_pkg::LIN_EXTRA_TIMES : 4'h0);
	assign break_length = state_reg.long_break_tx ?
		ube_pkg::LONG_BREAK_TIMES + {3'h0, nine_bit_mode} : char_times;

	ube_run_counter low_run
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.bit_tick  (bit_tick),
		.run_level (!line_now),
		.threshold (break_threshold),
		.hit       (break_hit)
	);

	ube_run_counter idle_run
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.bit_tick  (bit_tick),
		.run_level (line_now && state_reg.receiver_active_flag),
		.threshold (char_times),
		.hit       (idle_hit)
	);

	ube_run_counter break_run
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.bit_tick  (bit_tick),
		.run_level (state_reg.break_active),
		.threshold (break_length),
		.hit       (tx_break_hit)
	);

	// ==========================================================
	// next state
	logic [4:0] flags_now;
	logic [4:0] flags_set;

	always_comb
	begin
		state_next = state_reg;
		state_next.line_prev = line_now;
		state_next.tx_load = 1'b0;
		state_next.idle_set = 1'b0;

		// apb: read data captured in setup, answered in access
		if (setup_phase)
		begin
			state_next.pslverr = (addr_sel == 2'b00);
			if (addr_sel == 2'b01)
			begin
				state_next.prdata = {24'h000000, status_two_value};
			end
			else if (addr_sel == 2'b10)
			begin
				state_next.prdata = {24'h000000, control_three_value};
			end
			else
			begin
				state_next.prdata = 32'h00000000;
			end
		end

		// software writes; w1c flags cleared here, sets below win
		if (write_access && (addr_sel == 2'b01))
		begin
			if (pwdata[ube_pkg::S2_LIN_BREAK_FLAG])
			begin
				state_next.lin_break_flag = 1'b0;
			end
			if (pwdata[ube_pkg::S2_RX_EDGE_FLAG])
			begin
				state_next.rx_edge_flag = 1'b0;
			end
			state_next.rx_invert = pwdata[ube_pkg::S2_RX_INVERT];
			state_next.wake_idle_report = pwdata[ube_pkg::S2_WAKE_IDLE_REPORT];
			state_next.long_break_tx = pwdata[ube_pkg::S2_LONG_BREAK_TX];
			state_next.lin_break_detect_enable = pwdata[ube_pkg::S2_LIN_BREAK_DETECT];
		end
		else if (write_access && (addr_sel == 2'b10))
		begin
			state_next.tx_ninth_bit = pwdata[ube_pkg::C3_TX_NINTH_BIT];
			state_next.single_wire_tx_direction = pwdata[ube_pkg::C3_TX_DIRECTION];
			state_next.tx_invert = pwdata[ube_pkg::C3_TX_INVERT];
			state_next.overrun_irq_enable = pwdata[ube_pkg::C3_OVERRUN_IRQ_EN];
			state_next.noise_irq_enable = pwdata[ube_pkg::C3_NOISE_IRQ_EN];
			state_next.framing_irq_enable = pwdata[ube_pkg::C3_FRAMING_IRQ_EN];
			state_next.parity_irq_enable = pwdata[ube_pkg::C3_PARITY_IRQ_EN];
		end

		// hardware set events
		if (state_reg.lin_break_detect_enable && break_hit)
		begin
			state_next.lin_break_flag = 1'b1;
		end
		if (edge_seen)
		begin
			state_next.rx_edge_flag = 1'b1;
		end

		// receiver active from start bit edge until idle line
		if (edge_seen && !state_reg.receiver_active_flag)
		begin
			state_next.receiver_active_flag = 1'b1;
		end
		else if (idle_hit)
		begin
			state_next.receiver_active_flag = 1'b0;
		end

		// waking idle in standby only reported when asked
		if (idle_hit)
		begin
			state_next.idle_set = !receiver_standby || state_reg.wake_idle_report;
		end

		// error flags: status-one read arms, data read clears armed ones
		flags_now = {state_reg.rx_buffer_full_flag, state_reg.overrun_flag,
			state_reg.noise_flag, state_reg.framing_error_flag, state_reg.parity_error_flag};
		if (status_one_read)
		begin
			state_next.clear_armed = state_reg.clear_armed | flags_now;
		end
		if (data_reg_read)
		begin
			flags_now = flags_now & ~state_next.clear_armed;
			state_next.clear_armed = 5'h00;
		end
		flags_set = 5'h00;
		if (rx_char_done)
		begin
			if (state_reg.rx_buffer_full_flag)
			begin
				flags_set[3] = 1'b1;
			end
			else if (!state_reg.lin_break_detect_enable)
			begin
				// long break setting plays no part in framing judgement
				flags_set[4] = 1'b1;
				flags_set[2] = rx_noise_seen;
				flags_set[1] = rx_framing_bad;
				flags_set[0] = rx_parity_bad;
				state_next.rx_ninth_bit = nine_bit_mode && rx_ninth_in;
			end
		end
		flags_now = flags_now | flags_set;
		state_next.clear_armed = state_next.clear_armed & ~flags_set;
		state_next.rx_buffer_full_flag = flags_now[4];
		state_next.overrun_flag = flags_now[3];
		state_next.noise_flag = flags_now[2];
		state_next.framing_error_flag = flags_now[1];
		state_next.parity_error_flag = flags_now[0];

		// transmit data load with ninth bit in nine bit mode
		if (tx_data_write)
		begin
			state_next.tx_frame = {nine_bit_mode && state_reg.tx_ninth_bit, tx_data_byte};
			state_next.tx_load = 1'b1;
		end

		// break generation
		if (send_break_req && !state_reg.break_active)
		begin
			state_next.break_active = 1'b1;
		end
		else if (tx_break_hit)
		begin
			state_next.break_active = 1'b0;
		end

		state_next.txd_o = (state_next.break_active ? 1'b0 : tx_shift_bit)
			^ state_next.tx_invert;
	end

	// ==========================================================
	// state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= '0;
			state_reg.line_prev <= 1'b1;
			state_reg.txd_o <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// outputs
	assign prdata = state_reg.prdata;
	assign pready = psel && penable;
	assign pslverr = psel && penable && state_reg.pslverr;
	assign tx_frame = state_reg.tx_frame;
	assign tx_frame_load = state_reg.tx_load;
	assign tx_break_busy = state_reg.break_active;
	assign rx_line = line_now;
	assign idle_flag_set = state_reg.idle_set;
	assign rx_buffer_full_flag = state_reg.rx_buffer_full_flag;
	assign overrun_flag = state_reg.overrun_flag;
	assign noise_flag = state_reg.noise_flag;
	assign framing_error_flag = state_reg.framing_error_flag;
	assign parity_error_flag = state_reg.parity_error_flag;
	assign error_irq = (state_reg.overrun_flag && state_reg.overrun_irq_enable)
		|| (state_reg.noise_flag && state_reg.noise_irq_enable)
		|| (state_reg.framing_error_flag && state_reg.framing_irq_enable)
		|| (state_reg.parity_error_flag && state_reg.parity_irq_enable);
	assign txd_o = state_reg.txd_o;
	assign txd_oe = single_wire ? state_reg.single_wire_tx_direction : 1'b1;

endmodule

// >>> rtl/ube_pkg.sv
// constants for the break, edge and error control slice of the serial port
package ube_pkg;

	// ==========================================================
	// register map (byte addresses on the apb bus)
	localparam logic [7:0] STATUS_TWO_OFFSET    = 8'h00;
	localparam logic [7:0] CONTROL_THREE_OFFSET = 8'h04;

	// ==========================================================
	// serial_status_two field positions
	localparam int S2_LIN_BREAK_FLAG    = 7;
	localparam int S2_RX_EDGE_FLAG      = 6;
	localparam int S2_RX_INVERT         = 4;
	localparam int S2_WAKE_IDLE_REPORT  = 3;
	localparam int S2_LONG_BREAK_TX     = 2;
	localparam int S2_LIN_BREAK_DETECT  = 1;
	localparam int S2_RECEIVER_ACTIVE   = 0;

	// ==========================================================
	// serial_control_three field positions
	localparam int C3_RX_NINTH_BIT      = 7;
	localparam int C3_TX_NINTH_BIT      = 6;
	localparam int C3_TX_DIRECTION      = 5;
	localparam int C3_TX_INVERT         = 4;
	localparam int C3_OVERRUN_IRQ_EN    = 3;
	localparam int C3_NOISE_IRQ_EN      = 2;
	localparam int C3_FRAMING_IRQ_EN    = 1;
	localparam int C3_PARITY_IRQ_EN     = 0;

	// ==========================================================
	// reset values
	localparam logic [7:0] STATUS_TWO_RESET    = 8'h00;
	localparam logic [7:0] CONTROL_THREE_RESET = 8'h00;

	// ==========================================================
	// character and break lengths in bit times
	localparam logic [3:0] CHAR_BIT_TIMES     = 4'ha;
	localparam logic [3:0] LONG_BREAK_TIMES   = 4'hd;
	localparam logic [3:0] LIN_EXTRA_TIMES    = 4'h1;

endpackage

// >>> rtl/ube_run_counter.sv
// counts bit ticks while a level holds and pulses once at a threshold
`timescale 1ns/1ps
module ube_run_counter
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// run control
	input  wire logic       bit_tick,
	input  wire logic       run_level,
	input  wire logic [3:0] threshold,
	// result
	output logic            hit
);

	// ==========================================================
	// state
	typedef struct packed
	{
		logic [3:0] count;
		logic       hit;
	} ube_run_state_type;

	ube_run_state_type state_reg;
	ube_run_state_type state_next;

	// ==========================================================
	// next state
	always_comb
	begin
		state_next = state_reg;
		state_next.hit = 1'b0;
		if (!run_level)
		begin
			state_next.count = 4'h0;
		end
		else if (bit_tick && (state_reg.count != threshold))
		begin
			state_next.count = state_reg.count + 4'h1;
			// fires once per run, never again while the level holds
			state_next.hit = ((state_reg.count + 4'h1) == threshold);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign hit = state_reg.hit;

endmodule

// >>> test/ube_control_sva.sv
// assertion checker for the break, edge and error control slice
`timescale 1ns/1ps
module ube_control_sva
(
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// configuration and strobes
	input wire logic       nine_bit_mode,
	input wire logic       loop_select,
	input wire logic       receive_source_select,
	input wire logic       bit_tick,
	input wire logic       rx_char_done,
	input wire logic       data_reg_read,
	input wire logic       tx_data_write,
	input wire logic [7:0] tx_data_byte,
	input wire logic       send_break_req,
	// watched outputs
	input wire logic [8:0] tx_frame,
	input wire logic       tx_frame_load,
	input wire logic       tx_break_busy,
	input wire logic       rx_buffer_full_flag,
	input wire logic       overrun_flag,
	input wire logic       noise_flag,
	input wire logic       framing_error_flag,
	input wire logic       parity_error_flag,
	input wire logic       error_irq,
	input wire logic       txd_oe
);
	// ==========================================================
	// bit ticks seen while a break is sent
	logic [3:0] brk_cnt_reg;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			brk_cnt_reg <= 4'h0;
		else
			brk_cnt_reg <= tx_break_busy ? brk_cnt_reg + 4'(bit_tick) : 4'h0;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ==========================================================
	// assertions
	chk_frame_load: assert property (tx_data_write |=> tx_frame_load
		&& tx_frame[7:0] == $past(tx_data_byte)) else $error("frame not loaded");
	chk_load_cause: assert property (tx_frame_load |-> $past(tx_data_write))
		else $error("load without write");
	chk_frame_width: assert property (tx_data_write && !nine_bit_mode |=> !tx_frame[8])
		else $error("ninth bit in short frame");
	chk_overrun_set: assert property (rx_char_done && rx_buffer_full_flag |=> overrun_flag)
		else $error("overrun not set");
	chk_full_clear: assert property ($fell(rx_buffer_full_flag) |-> $past(data_reg_read))
		else $error("buffer full cleared early");
	chk_error_clear: assert property ($fell(framing_error_flag) || $fell(noise_flag)
		|| $fell(parity_error_flag) || $fell(overrun_flag) |-> $past(data_reg_read))
		else $error("error flag cleared early");
	chk_irq_quiet: assert property (!(overrun_flag || noise_flag || framing_error_flag
		|| parity_error_flag) |-> !error_irq) else $error("irq without flag");
	chk_break_start: assert property (send_break_req && !tx_break_busy |=> tx_break_busy)
		else $error("break not started");
	chk_break_len: assert property ($fell(tx_break_busy) |->
		(brk_cnt_reg - 4'(nine_bit_mode)) inside {4'ha, 4'hd}) else $error("break length");
	chk_pin_drive: assert property (!(loop_select && receive_source_select) |-> txd_oe)
		else $error("pin released outside single wire");

	cover property ($fell(tx_break_busy));
	cover property (overrun_flag && error_irq);
	cover property (tx_frame_load && tx_frame[8]);
endmodule

bind ube_control ube_control_sva chk_u (.*);

// >>> test/ube_remote_node.sv
// remote serial node driving the receive line and the single-wire pin
`timescale 1ns/1ps
module ube_remote_node
(
	// clock and bit timing
	input wire logic pclk,
	input wire logic bit_tick,
	// lines
	output logic     rxd,
	output logic     txd
);
	logic invert;

	initial
	begin
		invert = 1'b0;
		rxd = 1'b1;
		txd = 1'b1;
	end

	// polarity of this node's lines, idle level follows it
	task automatic set_invert(input logic v);
		invert = v;
		rxd <= ~v;
		txd <= ~v;
	endtask

	// hold a logical level for n bit ticks
	task automatic hold_level(input logic lvl, input int n);
		rxd <= lvl ^ invert;
		txd <= lvl ^ invert;
		repeat (n) @(posedge pclk iff bit_tick);
	endtask
endmodule

// >>> test/uart_break_edge_error_control_test.sv
// self-checking bench for the break, edge and error control slice
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end
module uart_break_edge_error_control_test;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0]  paddr, tx_data_byte, cfg;
	logic [31:0] pwdata, prdata, rdat;
	logic        nine_bit_mode, receiver_standby, loop_select, receive_source_select;
	logic        bit_tick, rx_char_done, rx_ninth_in, rx_framing_bad, rx_noise_seen;
	logic        rx_parity_bad, status_one_read, data_reg_read, tx_data_write;
	logic        send_break_req, tx_shift_bit, tx_frame_load, tx_break_busy, rx_line;
	logic        idle_flag_set, rx_buffer_full_flag, overrun_flag, noise_flag;
	logic        framing_error_flag, parity_error_flag, error_irq;
	logic        rxd_i, txd_i, txd_o, txd_oe, node_txd;
	logic [8:0]  tx_frame;
	logic [4:0]  flags;
	logic [1:0]  tdiv = 2'h0;
	int          checked = 0, error_cnt = 0, idle_cnt = 0, n;
	typedef struct packed {logic nine; logic twice; logic [2:0] qual; logic [3:0] en;
		logic [4:0] flags; logic irq;} ube_row_type;
	ube_row_type rows [6];

	ube_control dut_u (.*);
	ube_remote_node node_u (.pclk, .bit_tick, .rxd(rxd_i), .txd(node_txd));
	assign txd_i = txd_oe ? txd_o : node_txd;
	assign flags = {rx_buffer_full_flag, overrun_flag, noise_flag, framing_error_flag,
		parity_error_flag};

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		tdiv <= tdiv + 2'h1;
		bit_tick <= (tdiv == 2'h3);
		if (idle_flag_set === 1'b1)
			idle_cnt <= idle_cnt + 1;
	end

	// ==========================================================
	// tasks
	task automatic wrap_up();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] ex);
		repeat (4) @(posedge pclk);
		apb(1'b0, a, 32'h0);
		`CHK("prdata", {24'h0, ex}, rdat)
	endtask

	task automatic strobe(input int w);
		@(posedge pclk);
		rx_char_done <= (w == 0);
		status_one_read <= (w == 1);
		data_reg_read <= (w == 2);
		@(posedge pclk);
		{rx_char_done, status_one_read, data_reg_read} <= 3'h0;
	endtask

	initial
	begin
		repeat (40000) @(posedge pclk);
		error_cnt++;
		$display("mismatch watchdog expected end seen hang");
		wrap_up();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, tx_data_byte} = '0;
		{nine_bit_mode, receiver_standby, loop_select, receive_source_select} = '0;
		{rx_char_done, rx_ninth_in, rx_framing_bad, rx_noise_seen, rx_parity_bad} = '0;
		{status_one_read, data_reg_read, tx_data_write, send_break_req} = '0;
		tx_shift_bit = 1'b1;
		rows = '{{2'b00, 3'b001, 4'h1, 5'b10001, 1'b1}, {2'b00, 3'b001, 4'he, 5'b10001, 1'b0},
			{2'b00, 3'b010, 4'h2, 5'b10010, 1'b1}, {2'b10, 3'b100, 4'h4, 5'b10100, 1'b1},
			{2'b01, 3'b000, 4'h8, 5'b11000, 1'b1}, {2'b01, 3'b000, 4'h7, 5'b11000, 1'b0}};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rx_ninth_in <= 1'b1;
		apb(1'b1, 8'h00, 32'h4);
		foreach (rows[r])
		begin
			nine_bit_mode <= rows[r].nine;
			{rx_noise_seen, rx_framing_bad, rx_parity_bad} <= rows[r].qual;
			apb(1'b1, 8'h04, {28'h0, rows[r].en});
			strobe(0);
			if (rows[r].twice)
				strobe(0);
			repeat (2) @(posedge pclk);
			`CHK("flags", rows[r].flags, flags)
			`CHK("irq", rows[r].irq, error_irq)
			rd(8'h04, {rows[r].nine, 3'h0, rows[r].en});
			strobe(2);
			@(posedge pclk);
			`CHK("held", rows[r].flags, flags)
			strobe(1);
			strobe(2);
			repeat (2) @(posedge pclk);
			`CHK("cleared", 5'h00, flags)
			`CHK("irq off", 1'b0, error_irq)
		end
		$display("error rows done");
		rd(8'h00, 8'h04);
		apb(1'b1, 8'h00, 32'hffffff2f);
		rd(8'h00, 8'h0e);
		{rx_noise_seen, rx_framing_bad, rx_parity_bad} <= 3'b010;
		strobe(0);
		repeat (2) @(posedge pclk);
		`CHK("lin blocks", 5'h00, flags)
		apb(1'b0, 8'h08, 32'h0);
		`CHK("unmapped", 33'h100000000, {rerr, rdat})
		$display("register test done");
		for (int k = 0; k < 4; k++)
		begin
			cfg = 8'h02 | (8'(k[1]) << 4) | (8'(k[0]) << 3);
			apb(1'b1, 8'h00, 32'(cfg));
			node_u.set_invert(k[1]);
			nine_bit_mode <= k[0];
			receiver_standby <= k[1];
			node_u.hold_level(1'b1, 12);
			`CHK("rx line", 1'b1, rx_line)
			apb(1'b1, 8'h00, 32'(cfg | 8'hc0));
			rd(8'h00, cfg);
			n = idle_cnt;
			node_u.hold_level(1'b0, 10 + k[0]);
			node_u.hold_level(1'b1, 12);
			rd(8'h00, cfg | 8'h40);
			`CHK("idle", 32'(!k[1] || k[0]), 32'(idle_cnt - n))
			node_u.hold_level(1'b0, 11 + k[0]);
			node_u.hold_level(1'b1, 2);
			rd(8'h00, cfg | 8'hc1);
			apb(1'b1, 8'h00, 32'(cfg | 8'hc0));
			rd(8'h00, cfg | 8'h01);
		end
		apb(1'b1, 8'h00, 32'h0);
		node_u.set_invert(1'b0);
		receiver_standby <= 1'b0;
		$display("receive line test done");
		for (int k = 0; k < 2; k++)
		begin
			@(posedge pclk);
			nine_bit_mode <= k[0];
			apb(1'b1, 8'h04, 32'h40);
			@(posedge pclk);
			tx_data_write <= 1'b1;
			tx_data_byte <= 8'ha5;
			@(posedge pclk);
			tx_data_write <= 1'b0;
			#1;
			`CHK("load", 1'b1, tx_frame_load)
			`CHK("frame", {k[0], 8'ha5}, tx_frame)
		end
		for (int k = 0; k < 4; k++)
		begin
			@(posedge pclk);
			nine_bit_mode <= k[0];
			apb(1'b1, 8'h00, 32'(k[1]) << 2);
			apb(1'b1, 8'h04, 32'(k[0] ^ k[1]) << 4);
			@(posedge pclk iff bit_tick);
			send_break_req <= 1'b1;
			@(posedge pclk);
			send_break_req <= 1'b0;
			#1;
			`CHK("break pin", 1'(k[0] ^ k[1]), txd_o)
			n = 0;
			while (tx_break_busy === 1'b1 && n < 20)
			begin
				@(posedge pclk);
				if (bit_tick && tx_break_busy)
					n++;
			end
			`CHK("break len", 10 + k[0] + 3 * k[1], n)
			repeat (2) @(posedge pclk);
			#1;
			`CHK("idle pin", 1'(~(k[0] ^ k[1])), txd_o)
		end
		$display("transmit test done");
		@(posedge pclk);
		{loop_select, receive_source_select} <= 2'b11;
		apb(1'b1, 8'h04, 32'h0);
		#1;
		`CHK("pin in", 1'b0, txd_oe)
		apb(1'b1, 8'h04, 32'h30);
		#1;
		`CHK("pin out", 1'b1, txd_oe)
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		`CHK("reset pin", 1'b1, txd_o)
		rd(8'h04, 8'h00);
		rd(8'h00, 8'h00);
		$display("single wire and reset test done");
		wrap_up();
	end
endmodule
